// >>> include/gpibd_pkg.sv
/*
  Shared constants for the instrument bus port: line positions, interface
  message codes, status byte layout, handshake timing and state encodings.
  Assumes a 100 MHz core clock and one package compiled ahead of all users.
*/
package gpibd_pkg;
  // Positions of the management and handshake lines in the line vector
  localparam int LN_EOI  = 0;
  localparam int LN_DAV  = 1;
  localparam int LN_NRFD = 2;
  localparam int LN_NDAC = 3;
  localparam int LN_ATN  = 4;
  localparam int LN_IFC  = 5;
  localparam int LN_REN  = 6;
  localparam int LN_SRQ  = 7;

  // Interface messages sent with attention, seven bits
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;

  // Request-service bit of the status byte
  localparam logic [7:0] SB_RQS_MASK = 8'h40;

  // Byte path buffer: end flag above eight data bits
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 16;

  localparam int CLK_MHZ     = 100;
  localparam int T_SETTLE_NS = 2000;
  localparam int SETTLE_CYC  = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_IFC_NS    = 100000;
  localparam int IFC_CYC     = (T_IFC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RST_LINES = 8'h00;

  typedef enum logic [3:0] {
    SH_IDLE = 4'b0001,
    SH_SET  = 4'b0010,
    SH_RDY  = 4'b0100,
    SH_DAV  = 4'b1000
  } gpibd_sh_e;

  typedef enum logic [2:0] {
    AH_IDLE = 3'b001,
    AH_RDY  = 3'b010,
    AH_ACC  = 3'b100
  } gpibd_ah_e;
endpackage

// >>> include/gpibd_if.sv
/*
  Bus carrier joining the instrument end and the controller end.
  Every line is open drain: a party pulls it low by raising its enable.
  The resolved electrical levels are active low; a released line reads high.
*/
`timescale 1ns/1ps
interface gpibd_if;
  logic [7:0] dev_dio_o;
  logic [7:0] dev_dio_oe;
  logic [7:0] dev_ln_o;
  logic [7:0] dev_ln_oe;
  logic [7:0] ctl_dio_o;
  logic [7:0] ctl_dio_oe;
  logic [7:0] ctl_ln_o;
  logic [7:0] ctl_ln_oe;
  wire  [7:0] bus_dio_n;
  wire  [7:0] bus_ln_n;

  // Wired-AND of both parties
  assign bus_dio_n = (dev_dio_o | ~dev_dio_oe) & (ctl_dio_o | ~ctl_dio_oe);
  assign bus_ln_n  = (dev_ln_o | ~dev_ln_oe) & (ctl_ln_o | ~ctl_ln_oe);

  modport dev (
    output dev_dio_o, dev_dio_oe, dev_ln_o, dev_ln_oe,
    input  bus_dio_n, bus_ln_n
  );
  modport ctl (
    output ctl_dio_o, ctl_dio_oe, ctl_ln_o, ctl_ln_oe,
    input  bus_dio_n, bus_ln_n
  );
endinterface

// >>> rtl/gpibd_dev.sv
/*
  Instrument end of the bus port, with the talker byte buffer.
  Assumes the controller end keeps its own handshake and that the
  address input is static while addressed.
*/
// Contract
// - Three-wire source and acceptor handshake both ways
// - Talk measurement bytes when addressed to talk
// - Listen to controller bytes when addressed listen
// - Service request, remote, clear, trigger; no controller
// - Address one to thirty, respond only then
// - Interface clear aborts transfers, idles functions
// - Selected or universal clear triggers device clear
// - Go-to-local while addressed drops remote
// - Lockout blocks front-panel local until released
// - Remote enable plus listen address enters remote
// - Serial poll returns status byte with request
// - Device can assert service request line
// - Message bytes follow common command conventions
`timescale 1ns/1ps
module gpibd_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_flush,
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  // Depth must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  wire          full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire          empty = (wp_q == rp_q);
  wire          wr    = i_in_valid && !full;
  wire          rd    = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge i_core_clk) begin
    if (wr) begin
      mem[wp_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wr ? wp_q + 1'b1 : wp_q;
      rp_q <= rd ? rp_q + 1'b1 : rp_q;
    end
  end
endmodule

module gpibd_dev (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  gpibd_if.dev            bus,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_end,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  input  wire logic [7:0] i_status,
  input  wire logic       i_srq_req,
  input  wire logic       i_local_key,
  output logic            o_listen,
  output logic            o_talk,
  output logic            o_spoll,
  output logic            o_remote,
  output logic            o_lockout,
  output logic            o_dev_clear,
  output logic            o_trigger,
  output logic            o_ifc
);
  localparam logic [8:0] SETTLE_LD = 9'(gpibd_pkg::SETTLE_CYC - 1);

  function automatic logic is_addr(input logic [6:0] c, input logic [1:0] g,
                                   input logic [4:0] a);
    return (c == {g, a}) && (a != 5'h00);
  endfunction

  logic [15:0] sy1_q, sy2_q;
  gpibd_pkg::gpibd_sh_e sh_q, sh_d;
  gpibd_pkg::gpibd_ah_e ah_q, ah_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [8:0]  src_q;
  logic [7:0]  dio_oe_q, ln_oe_q, ln_d;
  logic        listen_d, talk_d, spoll_d, remote_d, lockout_d;
  logic        srq_q, srq_prev_q, rx_v_q;
  logic        pop;
  logic [8:0]  fifo_od;
  logic        fifo_ov;

  wire [7:0] b_dio = sy2_q[7:0];
  wire [7:0] b_ln  = sy2_q[15:8];
  wire atn  = b_ln[gpibd_pkg::LN_ATN];
  wire ifc  = b_ln[gpibd_pkg::LN_IFC];
  wire ren  = b_ln[gpibd_pkg::LN_REN];
  wire dav  = b_ln[gpibd_pkg::LN_DAV];
  wire nrfd = b_ln[gpibd_pkg::LN_NRFD];
  wire ndac = b_ln[gpibd_pkg::LN_NDAC];
  wire eoi  = b_ln[gpibd_pkg::LN_EOI];

  wire [6:0] cb    = b_dio[6:0];
  wire c_unl = (cb == gpibd_pkg::CMD_UNL);
  wire c_unt = (cb == gpibd_pkg::CMD_UNT);
  wire c_mla = is_addr(cb, gpibd_pkg::GRP_LISTEN, i_addr) && !c_unl;
  wire c_mta = is_addr(cb, gpibd_pkg::GRP_TALK, i_addr) && !c_unt;
  wire c_ota = (cb[6:5] == gpibd_pkg::GRP_TALK) && !c_mta;

  wire engage = !ifc && (atn || (o_listen && !rx_v_q));
  wire inv    = !ifc && (atn || o_listen);
  wire take   = (ah_q == gpibd_pkg::AH_RDY) && engage && dav;
  wire ct     = take && atn;
  wire dt     = take && !atn;
  wire sh_act = o_talk && !atn && !ifc;
  wire sh_have = o_spoll || fifo_ov;
  wire [7:0] sbyte = (i_status & ~gpibd_pkg::SB_RQS_MASK) |
                     (srq_q ? gpibd_pkg::SB_RQS_MASK : 8'h00);
  wire [8:0] src_d = o_spoll ? {1'b0, sbyte} : fifo_od;
  wire sh_go  = (sh_q == gpibd_pkg::SH_IDLE) && sh_act && sh_have;
  wire dclr_d = ct && ((cb == gpibd_pkg::CMD_DCL) ||
                       (o_listen && cb == gpibd_pkg::CMD_SDC));
  wire trig_d = ct && o_listen && (cb == gpibd_pkg::CMD_GET);
  // Set wins over the poll read that clears it
  wire srq_d  = (srq_q && !(pop && o_spoll)) || (i_srq_req && !srq_prev_q);

  // Only the talker drains the buffer, so a silent bus backs up the source
  gpibd_fifo #(.W(gpibd_pkg::FIFO_W), .D(gpibd_pkg::FIFO_D)) u_txq (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_flush     (o_dev_clear),
    .i_in_data   ({i_tx_end, i_tx_data}),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .o_out_data  (fifo_od),
    .o_out_valid (fifo_ov),
    .i_out_ready (pop && !o_spoll)
  );

  // Source handshake; attention or clear abandons the transfer, the byte stays queued
  always_comb begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    pop   = 1'b0;
    case (sh_q)
      gpibd_pkg::SH_IDLE: begin
        if (sh_go) begin
          sh_d  = gpibd_pkg::SH_SET;
          cnt_d = SETTLE_LD;
        end
      end
      gpibd_pkg::SH_SET: begin
        if (!sh_act) sh_d = gpibd_pkg::SH_IDLE;
        else if (cnt_q == 9'h000) sh_d = gpibd_pkg::SH_RDY;
        else cnt_d = cnt_q - 1'b1;
      end
      gpibd_pkg::SH_RDY: begin
        if (!sh_act) sh_d = gpibd_pkg::SH_IDLE;
        else if (!nrfd) sh_d = gpibd_pkg::SH_DAV;
      end
      gpibd_pkg::SH_DAV: begin
        if (!sh_act) begin
          sh_d = gpibd_pkg::SH_IDLE;
        end else if (!ndac) begin
          sh_d = gpibd_pkg::SH_IDLE;
          pop  = 1'b1;
        end
      end
      default: sh_d = gpibd_pkg::SH_IDLE;
    endcase
  end

  // Acceptor handshake; commands are always taken under attention while interface clear is released
  always_comb begin
    ah_d = ah_q;
    case (ah_q)
      gpibd_pkg::AH_IDLE: if (engage) ah_d = gpibd_pkg::AH_RDY;
      gpibd_pkg::AH_RDY: begin
        if (!engage) ah_d = gpibd_pkg::AH_IDLE;
        else if (dav) ah_d = gpibd_pkg::AH_ACC;
      end
      gpibd_pkg::AH_ACC: if (!dav || ifc) ah_d = gpibd_pkg::AH_IDLE;
      default: ah_d = gpibd_pkg::AH_IDLE;
    endcase
  end

  // Addressing and remote state
  always_comb begin
    listen_d  = o_listen;
    talk_d    = o_talk;
    spoll_d   = o_spoll;
    remote_d  = o_remote;
    lockout_d = o_lockout;
    if (ifc) begin
      listen_d = 1'b0;
      talk_d   = 1'b0;
      spoll_d  = 1'b0;
    end else if (ct) begin
      if (c_mla) listen_d = 1'b1;
      else if (c_unl || c_mta) listen_d = 1'b0;
      if (c_mta) talk_d = 1'b1;
      else if (c_unt || c_ota || c_mla) talk_d = 1'b0;
      if (cb == gpibd_pkg::CMD_SPE) spoll_d = 1'b1;
      else if (cb == gpibd_pkg::CMD_SPD) spoll_d = 1'b0;
    end
    if (!ren) begin
      remote_d  = 1'b0;
      lockout_d = 1'b0;
    end else begin
      if (ct && c_mla) remote_d = 1'b1;
      else if (ct && o_listen && cb == gpibd_pkg::CMD_GTL) remote_d = 1'b0;
      else if (i_local_key && !o_lockout) remote_d = 1'b0;
      if (ct && cb == gpibd_pkg::CMD_LLO) lockout_d = 1'b1;
    end
  end

  // Never drives attention, clear or remote enable: no controller role
  always_comb begin
    ln_d = gpibd_pkg::RST_LINES;
    ln_d[gpibd_pkg::LN_EOI]  = (sh_d != gpibd_pkg::SH_IDLE) &&
                               (sh_go ? src_d[8] : src_q[8]);
    ln_d[gpibd_pkg::LN_DAV]  = (sh_d == gpibd_pkg::SH_DAV);
    ln_d[gpibd_pkg::LN_NRFD] = inv && (ah_d != gpibd_pkg::AH_RDY);
    ln_d[gpibd_pkg::LN_NDAC] = inv && (ah_d != gpibd_pkg::AH_ACC);
    ln_d[gpibd_pkg::LN_SRQ]  = srq_d;
  end

  assign bus.dev_dio_o  = 8'h00;
  assign bus.dev_ln_o   = 8'h00;
  assign bus.dev_dio_oe = dio_oe_q;
  assign bus.dev_ln_oe  = ln_oe_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sh_q  <= gpibd_pkg::SH_IDLE;
      ah_q  <= gpibd_pkg::AH_IDLE;
      cnt_q <= '0;
      src_q <= '0;
    end else begin
      sy1_q <= ~{bus.bus_ln_n, bus.bus_dio_n};
      sy2_q <= sy1_q;
      sh_q  <= sh_d;
      ah_q  <= ah_d;
      cnt_q <= cnt_d;
      src_q <= sh_go ? src_d : src_q;
    end
  end

  // Bytes pass untouched; command syntax is parsed above this block
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_data <= '0;
      o_rx_end  <= 1'b0;
      rx_v_q    <= 1'b0;
    end else if (dt) begin
      o_rx_data <= b_dio;
      o_rx_end  <= eoi;
      rx_v_q    <= 1'b1;
    end else if (i_rx_ready) begin
      rx_v_q    <= 1'b0;
    end
  end
  assign o_rx_valid = rx_v_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dio_oe_q    <= gpibd_pkg::RST_LINES;
      ln_oe_q     <= gpibd_pkg::RST_LINES;
      o_listen    <= 1'b0;
      o_talk      <= 1'b0;
      o_spoll     <= 1'b0;
      o_remote    <= 1'b0;
      o_lockout   <= 1'b0;
      o_dev_clear <= 1'b0;
      o_trigger   <= 1'b0;
      o_ifc       <= 1'b0;
      srq_q       <= 1'b0;
      srq_prev_q  <= 1'b0;
    end else begin
      dio_oe_q    <= (sh_d == gpibd_pkg::SH_IDLE) ? 8'h00 : (sh_go ? src_d[7:0] : src_q[7:0]);
      ln_oe_q     <= ln_d;
      o_listen    <= listen_d;
      o_talk      <= talk_d;
      o_spoll     <= spoll_d;
      o_remote    <= remote_d;
      o_lockout   <= lockout_d;
      o_dev_clear <= dclr_d;
      o_trigger   <= trig_d;
      o_ifc       <= ifc;
      srq_q       <= srq_d;
      srq_prev_q  <= i_srq_req;
    end
  end
endmodule

// >>> rtl/gpibd_ctl.sv
/*
  Controller end of the bus port: sends bytes with or without attention,
  pulses interface clear, drives remote enable, and accepts talker bytes.
  Assumes the user changes i_atn only while o_tx_ready is high.
*/
`timescale 1ns/1ps
module gpibd_ctl #(
  parameter int IFC_CYC = gpibd_pkg::IFC_CYC
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  gpibd_if.ctl            bus,
  input  wire logic       i_ifc_req,
  input  wire logic       i_ren,
  input  wire logic       i_atn,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_end,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic       i_listen,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_end,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  output logic            o_srq
);
  localparam logic [8:0]  SETTLE_LD = 9'(gpibd_pkg::SETTLE_CYC - 1);
  localparam logic [15:0] IFC_LD    = 16'(IFC_CYC);

  logic [15:0] sy1_q, sy2_q;
  gpibd_pkg::gpibd_sh_e sh_q, sh_d;
  gpibd_pkg::gpibd_ah_e ah_q, ah_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [8:0]  src_q;
  logic [15:0] ifc_q, ifc_d;
  logic [7:0]  dio_oe_q, ln_oe_q, ln_d;
  logic        atn_q;

  wire [7:0] b_dio = sy2_q[7:0];
  wire [7:0] b_ln  = sy2_q[15:8];
  wire dav  = b_ln[gpibd_pkg::LN_DAV];
  wire nrfd = b_ln[gpibd_pkg::LN_NRFD];
  wire ndac = b_ln[gpibd_pkg::LN_NDAC];
  wire ifc_on = (ifc_q != 16'h0000);
  wire sh_go  = o_tx_ready && i_tx_valid;
  wire inv    = i_listen && !atn_q && !ifc_on;
  wire engage = inv && !o_rx_valid;
  wire take   = (ah_q == gpibd_pkg::AH_RDY) && engage && dav;

  always_comb begin
    sh_d  = sh_q;
    cnt_d = cnt_q;
    case (sh_q)
      gpibd_pkg::SH_IDLE: begin
        if (sh_go) begin
          sh_d  = gpibd_pkg::SH_SET;
          cnt_d = SETTLE_LD;
        end
      end
      gpibd_pkg::SH_SET: begin
        if (ifc_on) sh_d = gpibd_pkg::SH_IDLE;
        else if (cnt_q == 9'h000) sh_d = gpibd_pkg::SH_RDY;
        else cnt_d = cnt_q - 1'b1;
      end
      gpibd_pkg::SH_RDY: begin
        if (ifc_on) sh_d = gpibd_pkg::SH_IDLE;
        else if (!nrfd) sh_d = gpibd_pkg::SH_DAV;
      end
      gpibd_pkg::SH_DAV: if (ifc_on || !ndac) sh_d = gpibd_pkg::SH_IDLE;
      default: sh_d = gpibd_pkg::SH_IDLE;
    endcase
  end

  always_comb begin
    ah_d = ah_q;
    case (ah_q)
      gpibd_pkg::AH_IDLE: if (engage) ah_d = gpibd_pkg::AH_RDY;
      gpibd_pkg::AH_RDY: begin
        if (!engage) ah_d = gpibd_pkg::AH_IDLE;
        else if (dav) ah_d = gpibd_pkg::AH_ACC;
      end
      gpibd_pkg::AH_ACC: if (!dav) ah_d = gpibd_pkg::AH_IDLE;
      default: ah_d = gpibd_pkg::AH_IDLE;
    endcase
  end

  // A new clear request while one runs is ignored
  always_comb begin
    ifc_d = ifc_q;
    if (ifc_on) ifc_d = ifc_q - 1'b1;
    else if (i_ifc_req) ifc_d = IFC_LD;
  end

  always_comb begin
    ln_d = gpibd_pkg::RST_LINES;
    ln_d[gpibd_pkg::LN_EOI]  = (sh_d != gpibd_pkg::SH_IDLE) && (sh_go ? i_tx_end : src_q[8]);
    ln_d[gpibd_pkg::LN_DAV]  = (sh_d == gpibd_pkg::SH_DAV);
    ln_d[gpibd_pkg::LN_NRFD] = inv && (ah_d != gpibd_pkg::AH_RDY);
    ln_d[gpibd_pkg::LN_NDAC] = inv && (ah_d != gpibd_pkg::AH_ACC);
    // Attention follows the user while idle so it can drop without a byte
    ln_d[gpibd_pkg::LN_ATN]  = o_tx_ready ? i_atn : atn_q;
    ln_d[gpibd_pkg::LN_IFC]  = (ifc_d != 16'h0000);
    ln_d[gpibd_pkg::LN_REN]  = i_ren;
  end

  assign bus.ctl_dio_o  = 8'h00;
  assign bus.ctl_ln_o   = 8'h00;
  assign bus.ctl_dio_oe = dio_oe_q;
  assign bus.ctl_ln_oe  = ln_oe_q;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sh_q  <= gpibd_pkg::SH_IDLE;
      ah_q  <= gpibd_pkg::AH_IDLE;
      cnt_q <= '0;
      src_q <= '0;
      ifc_q <= '0;
      atn_q <= 1'b0;
    end else begin
      sy1_q <= ~{bus.bus_ln_n, bus.bus_dio_n};
      sy2_q <= sy1_q;
      sh_q  <= sh_d;
      ah_q  <= ah_d;
      cnt_q <= cnt_d;
      src_q <= sh_go ? {i_tx_end, i_tx_data} : src_q;
      ifc_q <= ifc_d;
      atn_q <= o_tx_ready ? i_atn : atn_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dio_oe_q   <= gpibd_pkg::RST_LINES;
      ln_oe_q    <= gpibd_pkg::RST_LINES;
      o_tx_ready <= 1'b0;
      o_rx_data  <= '0;
      o_rx_end   <= 1'b0;
      o_rx_valid <= 1'b0;
      o_srq      <= 1'b0;
    end else begin
      dio_oe_q   <= (sh_d == gpibd_pkg::SH_IDLE) ? 8'h00 : (sh_go ? i_tx_data : src_q[7:0]);
      ln_oe_q    <= ln_d;
      o_tx_ready <= (sh_d == gpibd_pkg::SH_IDLE) && (ifc_d == 16'h0000) && !sh_go;
      o_srq      <= b_ln[gpibd_pkg::LN_SRQ];
      if (take) begin
        o_rx_data  <= b_dio;
        o_rx_end   <= b_ln[gpibd_pkg::LN_EOI];
        o_rx_valid <= 1'b1;
      end else if (i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/gpibd_properties.sv
/*
  Concurrent checks on the carrier between the instrument end and the
  controller end. Assumes the controller end runs with IFC_CYC cycles of IFC.
*/
`timescale 1ns/1ps
module gpibd_properties #(
  parameter int IFC_CYC = 8
) (
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic [7:0] dev_dio_oe,
  input wire logic [7:0] dev_ln_oe,
  input wire logic [7:0] ctl_ln_oe,
  input wire logic [7:0] bus_ln_n
);
  localparam int DAV = gpibd_pkg::LN_DAV;
  localparam int NRFD = gpibd_pkg::LN_NRFD;
  localparam int NDAC = gpibd_pkg::LN_NDAC;
  localparam int ATN = gpibd_pkg::LN_ATN;
  localparam int IFC = gpibd_pkg::LN_IFC;
  localparam int REN = gpibd_pkg::LN_REN;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // A counter, since the real IFC length is far beyond any repetition
  logic [15:0] ifc_cnt_q;
  logic [15:0] ifc_cnt_d;
  assign ifc_cnt_d = ctl_ln_oe[IFC] ? ifc_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) ifc_cnt_q <= 16'h0000;
    else ifc_cnt_q <= ifc_cnt_d;
  end
  sequence ifc_seen;
    !bus_ln_n[IFC] [*2];
  endsequence
  sequence src_idle;
    !dev_ln_oe[DAV] && (dev_dio_oe == 8'h00);
  endsequence
  no_ctl_lines_a: assert property (!dev_ln_oe[ATN] && !dev_ln_oe[IFC] && !dev_ln_oe[REN])
    else $error("device drives a controller line");
  dio_hold_a: assert property (dev_ln_oe[DAV] && $past(dev_ln_oe[DAV]) |-> $stable(dev_dio_oe))
    else $error("data changed while DAV held");
  dav_wait_a: assert property ($rose(dev_ln_oe[DAV]) |-> $past(bus_ln_n[NRFD], 2))
    else $error("DAV raised while NRFD asserted");
  dav_release_a: assert property ($fell(dev_ln_oe[DAV]) && bus_ln_n[ATN] && bus_ln_n[IFC]
    |-> $past(bus_ln_n[NDAC], 2))
    else $error("DAV dropped before NDAC release");
  ndac_release_a: assert property ($fell(dev_ln_oe[NDAC]) && !bus_ln_n[ATN] && bus_ln_n[IFC]
    |-> !$past(bus_ln_n[DAV]))
    else $error("NDAC released without DAV");
  ifc_abort_a: assert property (ifc_seen |-> ##[0:4] src_idle)
    else $error("source not idle after IFC");
  ifc_length_a: assert property ($fell(ctl_ln_oe[IFC]) |-> ifc_cnt_q == IFC_CYC)
    else $error("IFC pulse length wrong");
  ifc_bound_a: assert property (ifc_cnt_q <= IFC_CYC)
    else $error("IFC pulse too long");
endmodule

// >>> verif/instrument_gpib_device_interface_test.sv
/*
  Self-checking bench: both bus ends face each other on one carrier.
  Assumes the package, carrier and design files are compiled first.
*/
`timescale 1ns/1ps
module instrument_gpib_device_interface_test;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic c_ifc = 1'h0, c_ren = 1'h0, c_atn = 1'h0, c_end = 1'h0, c_txv = 1'h0;
  logic c_lsn = 1'h0, c_rrdy = 1'h1, c_trdy, c_rend, c_rxv, c_srq;
  logic [7:0] c_txd = 8'h00, c_rxd, d_txd = 8'h00, d_stat = 8'h05, d_rxd;
  logic [4:0] d_addr = 5'h05;
  logic d_tend = 1'h0, d_txv = 1'h0, d_srq = 1'h0, d_key = 1'h0, d_trdy, d_rend, d_rxv;
  logic d_lsn, d_tlk, d_spl, d_rem, d_lck, d_clr, d_trg, d_ifc;
  logic [8:0] rq[$], dq[$];
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_trg = 0, n_clr = 0;
  gpibd_if gpibd_if_inst ();
  gpibd_dev gpibd_dev_inst (.i_core_clk(clk), .i_resetn(rst_n), .bus(gpibd_if_inst.dev),
    .i_addr(d_addr), .i_tx_data(d_txd), .i_tx_end(d_tend), .i_tx_valid(d_txv),
    .o_tx_ready(d_trdy), .o_rx_data(d_rxd), .o_rx_end(d_rend), .o_rx_valid(d_rxv),
    .i_rx_ready(1'h1), .i_status(d_stat), .i_srq_req(d_srq), .i_local_key(d_key),
    .o_listen(d_lsn), .o_talk(d_tlk), .o_spoll(d_spl), .o_remote(d_rem), .o_lockout(d_lck),
    .o_dev_clear(d_clr), .o_trigger(d_trg), .o_ifc(d_ifc));
  gpibd_ctl #(.IFC_CYC(8)) gpibd_ctl_inst (.i_core_clk(clk), .i_resetn(rst_n),
    .bus(gpibd_if_inst.ctl), .i_ifc_req(c_ifc), .i_ren(c_ren), .i_atn(c_atn),
    .i_tx_data(c_txd), .i_tx_end(c_end), .i_tx_valid(c_txv), .o_tx_ready(c_trdy),
    .i_listen(c_lsn), .o_rx_data(c_rxd), .o_rx_end(c_rend), .o_rx_valid(c_rxv),
    .i_rx_ready(c_rrdy), .o_srq(c_srq));
  gpibd_properties #(.IFC_CYC(8)) gpibd_properties_inst (.i_core_clk(clk), .i_resetn(rst_n),
    .dev_dio_oe(gpibd_if_inst.dev_dio_oe), .dev_ln_oe(gpibd_if_inst.dev_ln_oe),
    .ctl_ln_oe(gpibd_if_inst.ctl_ln_oe), .bus_ln_n(gpibd_if_inst.bus_ln_n));
  always #5 clk = ~clk;
  // Sampled mid-cycle so flop updates of the rising edge have landed
  always @(negedge clk) begin
    if (c_rxv === 1'h1 && c_rrdy) rq.push_back({c_rend, c_rxd});
    if (d_rxv === 1'h1) dq.push_back({d_rend, d_rxd});
    if (d_trg === 1'h1) n_trg++;
    if (d_clr === 1'h1) n_clr++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Holds the request until ready is seen at an edge, then waits for idle
  task automatic send(logic [7:0] b, logic a, logic e = 1'h0);
    int k;
    @(posedge clk);
    c_atn <= a;
    c_txd <= b;
    c_end <= e;
    c_txv <= 1'h1;
    @(negedge clk);
    for (k = 0; k < 500 && c_trdy !== 1'h1; k++) @(negedge clk);
    @(posedge clk);
    c_txv <= 1'h0;
    @(negedge clk);
    for (k = 0; k < 900 && c_trdy !== 1'h1; k++) @(negedge clk);
    chk("ctl idle", 9'h001, c_trdy);
    tick(3);
  endtask
  task automatic talk_on();
    send(gpibd_pkg::CMD_UNL, 1'h1);
    send(8'h45, 1'h1);
    @(posedge clk);
    c_atn <= 1'h0;
    c_lsn <= 1'h1;
    tick(8);
  endtask
  task automatic wait_q(int n);
    for (int k = 0; k < 6000 && rq.size() < n; k++) @(negedge clk);
  endtask
  task automatic t_listen();
    c_ren <= 1'h1;
    send(gpibd_pkg::CMD_UNT, 1'h1);
    send(8'h25, 1'h1);
    chk("listen", 9'h001, d_lsn);
    chk("talk", 9'h000, d_tlk);
    chk("remote", 9'h001, d_rem);
    send(8'h2A, 1'h0);
    send(8'h0A, 1'h0, 1'h1);
    chk("rx count", 9'h002, dq.size());
    chk("rx byte 0", 9'h02A, dq[0]);
    chk("rx byte 1", 9'h10A, dq[1]);
  endtask
  task automatic t_cmds();
    send(gpibd_pkg::CMD_GET, 1'h1);
    chk("trigger", 9'h001, n_trg);
    send(gpibd_pkg::CMD_SDC, 1'h1);
    chk("sel clear", 9'h001, n_clr);
    send(gpibd_pkg::CMD_UNL, 1'h1);
    send(gpibd_pkg::CMD_DCL, 1'h1);
    chk("all clear", 9'h002, n_clr);
    send(8'h25, 1'h1);
    send(gpibd_pkg::CMD_LLO, 1'h1);
    chk("lockout", 9'h001, d_lck);
    @(posedge clk);
    d_key <= 1'h1;
    @(posedge clk);
    d_key <= 1'h0;
    tick(3);
    chk("locked remote", 9'h001, d_rem);
    send(gpibd_pkg::CMD_GTL, 1'h1);
    chk("local", 9'h000, d_rem);
    send(8'h45, 1'h1);
    chk("talk only", 9'h001, {d_lsn, d_tlk});
    c_ren <= 1'h0;
    tick(4);
    chk("lockout off", 9'h000, d_lck);
    send(gpibd_pkg::CMD_UNT, 1'h1);
  endtask
  task automatic t_addr();
    send(8'h26, 1'h1);
    chk("other addr", 9'h000, d_lsn);
    d_addr <= 5'h00;
    send(8'h20, 1'h1);
    chk("addr zero", 9'h000, d_lsn);
    d_addr <= 5'h05;
  endtask
  task automatic t_fill();
    for (int n = 0; n < 17; n++) begin
      @(posedge clk);
      d_txd <= 8'hA0 + n[7:0];
      d_tend <= (n == 15);
      d_txv <= 1'h1;
    end
    @(negedge clk);
    chk("fifo full", 9'h000, d_trdy);
    @(posedge clk);
    d_txv <= 1'h0;
    c_rrdy <= 1'h0;
    rq.delete();
    talk_on();
    tick(800);
    chk("stalled", 9'h001, c_rxv);
    chk("dio wire", {1'h0, ~8'hA1}, gpibd_if_inst.bus_dio_n);
    @(posedge clk);
    c_rrdy <= 1'h1;
    wait_q(16);
    for (int n = 0; n < 16; n++) chk("talk byte", {n == 15, 8'hA0 + n[7:0]}, rq[n]);
    chk("fifo empty", 9'h001, d_trdy);
    c_lsn <= 1'h0;
    send(gpibd_pkg::CMD_UNT, 1'h1);
  endtask
  task automatic t_spoll();
    @(posedge clk);
    d_srq <= 1'h1;
    tick(6);
    chk("srq line", 9'h000, gpibd_if_inst.bus_ln_n[7]);
    chk("srq seen", 9'h001, c_srq);
    send(gpibd_pkg::CMD_SPE, 1'h1);
    rq.delete();
    talk_on();
    wait_q(1);
    chk("status", 9'h045, rq[0][7:0]);
    tick(6);
    chk("srq clear", 9'h001, gpibd_if_inst.bus_ln_n[7]);
    c_lsn <= 1'h0;
    d_srq <= 1'h0;
    send(gpibd_pkg::CMD_SPD, 1'h1);
    send(gpibd_pkg::CMD_UNT, 1'h1);
  endtask
  task automatic t_ifc();
    @(posedge clk);
    d_txd <= 8'h11;
    d_txv <= 1'h1;
    @(posedge clk);
    d_txv <= 1'h0;
    rq.delete();
    talk_on();
    c_ifc <= 1'h1;
    @(posedge clk);
    c_ifc <= 1'h0;
    tick(5);
    chk("ifc level", 9'h001, d_ifc);
    tick(12);
    chk("unaddressed", 9'h000, {d_lsn, d_tlk});
    chk("dio idle", 9'h0FF, gpibd_if_inst.bus_dio_n);
    chk("no byte", 9'h000, rq.size());
    c_lsn <= 1'h0;
    send(gpibd_pkg::CMD_DCL, 1'h1);
    chk("flushed", 9'h001, d_trdy);
    rq.delete();
    talk_on();
    tick(300);
    chk("flushed byte", 9'h000, rq.size());
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    tick(2);
    t_listen();
    t_cmds();
    t_addr();
    t_fill();
    t_spoll();
    t_ifc();
    give_verdict();
  end
endmodule
